// file: shared/pimage_cfg.svh
// constants of the process-image control and watchdog block
// Notes on behaviour
// - sensor-mode GPIO shows temperature as 16-bit word, low/high byte, GPIO 0..3
// - whole-degree sensor: word is degrees times 256, integer in high byte
// - tenth-degree sensor: word is degrees times 10
// - tenth-degree sensor: high byte MSB set when temperature is negative
// - sensor-mode GPIO shows humidity as 16-bit word, low/high byte per GPIO
// - whole-percent sensor: humidity word is percent times 256
// - tenth-percent sensor: humidity word is percent times 10
// - 32 backup bytes each way; restore bytes show stored data after restart
// - stored backup stays unchanged while backup not enabled again
// - backup enabled and power lost: store latest backup bytes from host
// - host sends expected model code; mismatch reported as error
// - transfer-mode byte reserved; host writes to it are ignored
// - watchdog select defaults 0 (off); codes 1..10 give 16 ms doubling to 8 s
// - enabled watchdog enters safe state when gap between valid cycles exceeds timeout
// - invalid cycle (bad checksum) does not restart the watchdog timeout
// - host sends control bytes; device returns version, model, state, warnings
// - each GPIO is input, output or climate sensor via its direction and sensor bits in the shared function byte
// - safe state: outputs off, pwm high impedance, backup stored if enabled, held till power cycle
// - backup disabled after reset until host writes one to enable bit
`ifndef PIMAGE_CFG_SVH
`define PIMAGE_CFG_SVH

// ======================================================
// register offsets
`define OFS_EXPECTED_MODEL 8'h00
`define OFS_TRANSFER_MODE 8'h01
`define OFS_SETTINGS_FIRST 8'h02
`define OFS_SETTINGS_SECOND 8'h03
`define OFS_GPIO_FUNCTION 8'h04
`define OFS_STATE_REPORT 8'h05
`define OFS_WARNING_REPORT 8'h06
`define OFS_FIRMWARE 8'h07
`define OFS_HARDWARE 8'h08
`define OFS_MODEL_REPORT 8'h09
`define OFS_CLIMATE_BASE 8'h10
`define OFS_BACKUP_BASE 8'h40
`define OFS_RESTORE_BASE 8'h60

// ======================================================
// field positions
`define BIT_SAFE_REQUEST 0
`define BIT_RESTORE_MIRROR 1
`define BIT_BACKUP_ENABLE 2
`define BIT_STATE_SAFE 0
`define BIT_STATE_WATCHDOG 1
`define BIT_STATE_MODEL_ERR 2
`define BIT_STATE_STORED 3
`define BIT_WARN_RESERVED_WD 0
`define BIT_WARN_NO_RESTORE 1

// ======================================================
// reset values and timing
`define RST_BYTE 8'h00
`define WD_SEL_OFF 4'h0
`define WD_SEL_MAX 4'ha
`define WD_BASE_MS 16
`define CLOCK_KHZ 100000

`endif

// file: shared/pimage_pkg.sv
// types of the process-image control and watchdog block
package pimage_pkg;

	typedef enum logic [0:0] {
		OP_RUN = 1'b0,
		OP_SAFE = 1'b1
	} op_state_e;

	typedef struct packed {
		logic [7:0] model_byte;
		logic model_seen;
		logic [3:0] wd_sel;
		logic restore_mirror;
		logic backup_enable;
		logic [7:0] gpio_function;
		logic [3:0][15:0] temperature;
		logic [3:0][15:0] humidity;
		logic [31:0][7:0] backup_bytes;
		logic [31:0][7:0] restore_bytes;
		logic restore_loaded;
		logic [30:0] wd_count;
		op_state_e op_state;
		logic stored;
		logic store_pulse;
		logic [7:0] rdata;
		logic [3:0] gpio_output;
		logic [3:0] gpio_sensor;
		logic outputs_off;
		logic pwm_hiz;
	} pimage_state_s;

endpackage

// file: src/pimage_ctrl.sv
// process-image control bytes, climate results, backup area and watchdog
`timescale 1ns/1ns
`include "pimage_cfg.svh"

module pimage_ctrl
	import pimage_pkg::*;
#(
	parameter int WD_BASE_CYCLES = `WD_BASE_MS * (`CLOCK_KHZ),
	parameter logic [7:0] OWN_MODEL = 8'h4d,
	parameter logic [7:0] FIRMWARE_VERSION = 8'h01,
	parameter logic [7:0] HARDWARE_VERSION = 8'h01
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic i_cycle_done,
	input wire logic i_cycle_crc_ok,
	input wire logic i_sensor_update,
	input wire logic [1:0] i_sensor_index,
	input wire logic i_sensor_tenths,
	input wire logic i_sensor_negative,
	input wire logic [14:0] i_sensor_temp,
	input wire logic [14:0] i_sensor_humid,
	input wire logic i_restore_valid,
	input wire logic [255:0] i_restore_image,
	input wire logic i_power_fail,
	output logic [7:0] o_rdata,
	output logic [3:0] o_gpio_output,
	output logic [3:0] o_gpio_sensor,
	output logic o_outputs_off,
	output logic o_pwm_hiz,
	output logic o_safe_state,
	output logic o_store_strobe,
	output logic [255:0] o_backup_image
);

	// ======================================================
	// state
	pimage_state_s state_reg;
	pimage_state_s state_next;

	logic wd_enabled;
	logic [30:0] wd_limit;
	logic valid_cycle;
	logic model_error;
	logic [7:0] state_report;
	logic [7:0] warn_report;
	logic [15:0] temp_word;
	logic [15:0] humid_word;
	logic [1:0] climate_idx;
	logic [4:0] area_idx;

	// ======================================================
	// watchdog decode
	always_comb begin
		wd_enabled = (state_reg.wd_sel != `WD_SEL_OFF);
		if (state_reg.wd_sel > `WD_SEL_MAX) begin
			wd_enabled = 1'b0;
		end
		// doubling from the base count; shift stays small so no overflow
		wd_limit = 31'(WD_BASE_CYCLES) << (state_reg.wd_sel - 4'h1);
		if (!wd_enabled) begin
			wd_limit = '0;
		end
	end

	assign valid_cycle = i_cycle_done & i_cycle_crc_ok;
	assign model_error = state_reg.model_seen & (state_reg.model_byte != OWN_MODEL);

	// ======================================================
	// sensor word forming
	always_comb begin
		if (i_sensor_tenths) begin
			temp_word = {1'b0, i_sensor_temp};
			temp_word[15] = i_sensor_negative;
			humid_word = {1'b0, i_sensor_humid};
		end else begin
			temp_word = {i_sensor_temp[7:0], 8'h00};
			humid_word = {i_sensor_humid[7:0], 8'h00};
		end
	end

	// ======================================================
	// status bytes
	always_comb begin
		state_report = `RST_BYTE;
		state_report[`BIT_STATE_SAFE] = (state_reg.op_state == OP_SAFE);
		state_report[`BIT_STATE_WATCHDOG] = wd_enabled;
		state_report[`BIT_STATE_MODEL_ERR] = model_error;
		state_report[`BIT_STATE_STORED] = state_reg.stored;
		warn_report = `RST_BYTE;
		warn_report[`BIT_WARN_RESERVED_WD] = (state_reg.wd_sel > `WD_SEL_MAX);
		warn_report[`BIT_WARN_NO_RESTORE] = ~state_reg.restore_loaded;
	end

	assign climate_idx = i_addr[3:2];
	assign area_idx = i_addr[4:0];

	// ======================================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.store_pulse = 1'b0;
		state_next.rdata = `RST_BYTE;

		// register writes
		if (i_write) begin
			case (i_addr)
				`OFS_EXPECTED_MODEL: begin
					state_next.model_byte = i_wdata;
					state_next.model_seen = 1'b1;
				end
				`OFS_TRANSFER_MODE: begin
					state_next.model_seen = state_reg.model_seen;
				end
				`OFS_SETTINGS_FIRST: begin
					state_next.wd_sel = i_wdata[3:0];
				end
				`OFS_SETTINGS_SECOND: begin
					state_next.restore_mirror = i_wdata[`BIT_RESTORE_MIRROR];
					state_next.backup_enable = i_wdata[`BIT_BACKUP_ENABLE];
					if (i_wdata[`BIT_SAFE_REQUEST]) begin
						state_next.op_state = OP_SAFE;
					end
				end
				`OFS_GPIO_FUNCTION: begin
					state_next.gpio_function = i_wdata;
				end
				default: begin
					if (i_addr[7:5] == `OFS_BACKUP_BASE >> 5) begin
						state_next.backup_bytes[area_idx] = i_wdata;
					end
				end
			endcase
		end

		// register reads, data in the next cycle only
		if (i_read) begin
			case (i_addr)
				`OFS_SETTINGS_FIRST: state_next.rdata = {4'h0, state_reg.wd_sel};
				`OFS_SETTINGS_SECOND: begin
					state_next.rdata[`BIT_RESTORE_MIRROR] = state_reg.restore_mirror;
					state_next.rdata[`BIT_BACKUP_ENABLE] = state_reg.backup_enable;
				end
				`OFS_GPIO_FUNCTION: state_next.rdata = state_reg.gpio_function;
				`OFS_STATE_REPORT: state_next.rdata = state_report;
				`OFS_WARNING_REPORT: state_next.rdata = warn_report;
				`OFS_FIRMWARE: state_next.rdata = FIRMWARE_VERSION;
				`OFS_HARDWARE: state_next.rdata = HARDWARE_VERSION;
				`OFS_MODEL_REPORT: state_next.rdata = OWN_MODEL;
				default: begin
					if (i_addr[7:4] == `OFS_CLIMATE_BASE >> 4) begin
						case (i_addr[1:0])
							2'h0: state_next.rdata = state_reg.temperature[climate_idx][7:0];
							2'h1: state_next.rdata = state_reg.temperature[climate_idx][15:8];
							2'h2: state_next.rdata = state_reg.humidity[climate_idx][7:0];
							default: state_next.rdata = state_reg.humidity[climate_idx][15:8];
						endcase
					end else if (i_addr[7:5] == `OFS_RESTORE_BASE >> 5) begin
						// restore bytes to host; mirror shows last backup bytes
						if (state_reg.restore_mirror) begin
							state_next.rdata = state_reg.backup_bytes[area_idx];
						end else begin
							state_next.rdata = state_reg.restore_bytes[area_idx];
						end
					end
				end
			endcase
		end

		// ======================================================
		// gpio functions
		// sensor bit wins over direction bit
		state_next.gpio_sensor = state_next.gpio_function[7:4];
		state_next.gpio_output = state_next.gpio_function[3:0] & ~state_next.gpio_function[7:4];
		// sensor results kept only in sensor mode
		if (i_sensor_update && state_reg.gpio_function[4 + i_sensor_index]) begin
			state_next.temperature[i_sensor_index] = temp_word;
			state_next.humidity[i_sensor_index] = humid_word;
		end
		for (int g = 0; g < 4; g++) begin
			if (!state_next.gpio_sensor[g]) begin
				state_next.temperature[g] = '0;
				state_next.humidity[g] = '0;
			end
		end

		// ======================================================
		// restore image from nonvolatile store
		if (i_restore_valid && !state_reg.restore_loaded) begin
			// image kept by store outside, loaded once per power-up
			state_next.restore_bytes = i_restore_image;
			state_next.restore_loaded = 1'b1;
		end

		// ======================================================
		// watchdog
		if (!wd_enabled || valid_cycle) begin
			state_next.wd_count = '0;
		end else if (state_reg.wd_count <= wd_limit) begin
			state_next.wd_count = state_reg.wd_count + 31'h1;
		end
		// gap beyond timeout trips safe state
		if (wd_enabled && (state_reg.wd_count > wd_limit)) begin
			state_next.op_state = OP_SAFE;
		end

		// ======================================================
		// safe state and backup store
		case (state_reg.op_state)
			OP_RUN: begin
				state_next.outputs_off = 1'b0;
				state_next.pwm_hiz = 1'b0;
			end
			OP_SAFE: begin
				// held until power cycle; only reset leaves it
				state_next.op_state = OP_SAFE;
				state_next.outputs_off = 1'b1;
				state_next.pwm_hiz = 1'b1;
				state_next.gpio_output = 4'h0;
			end
			default: state_next.op_state = OP_SAFE;
		endcase
		// one store per power-up saves wear on the nonvolatile cells
		if (state_reg.backup_enable && !state_reg.stored &&
			(i_power_fail || state_reg.op_state == OP_SAFE)) begin
			// store latest backup bytes / store on safe entry
			state_next.store_pulse = 1'b1;
			state_next.stored = 1'b1;
		end
	end

	// ======================================================
	// registers
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ======================================================
	// outputs
	assign o_rdata = state_reg.rdata;
	assign o_gpio_output = state_reg.gpio_output;
	assign o_gpio_sensor = state_reg.gpio_sensor;
	assign o_outputs_off = state_reg.outputs_off;
	assign o_pwm_hiz = state_reg.pwm_hiz;
	assign o_safe_state = (state_reg.op_state == OP_SAFE);
	assign o_store_strobe = state_reg.store_pulse;
	assign o_backup_image = state_reg.backup_bytes;

endmodule

// file: sim/pimage_ctrl_assertions.sv
// port assertions of the process-image controller
`timescale 1ns/1ns
`include "pimage_cfg.svh"
module pimage_ctrl_checker #(
	parameter int WD_BASE_CYCLES = 10
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic i_power_fail,
	input wire logic [7:0] o_rdata,
	input wire logic [3:0] o_gpio_output,
	input wire logic [3:0] o_gpio_sensor,
	input wire logic o_outputs_off,
	input wire logic o_pwm_hiz,
	input wire logic o_safe_state,
	input wire logic o_store_strobe,
	input wire logic [255:0] o_backup_image
);
	// ======================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	property p_rdata_idle; !$past(i_read) |-> o_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data out of slot");
	property p_mode_rsvd; $past(i_read && i_addr == `OFS_TRANSFER_MODE) |-> o_rdata == 8'h00;
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode byte not zero");
	property p_safe_hold; o_safe_state |=> o_safe_state; endproperty
	a_safe_hold: assert property (p_safe_hold) else $error("safe state left");
	property p_safe_out; $rose(o_safe_state) |=> o_outputs_off && o_pwm_hiz; endproperty
	a_safe_out: assert property (p_safe_out) else $error("outputs not off in safe");
	property p_out_off; o_outputs_off |-> o_gpio_output == 4'h0; endproperty
	a_out_off: assert property (p_out_off) else $error("gpio driven while off");
	property p_disjoint; (o_gpio_output & o_gpio_sensor) == 4'h0; endproperty
	a_disjoint: assert property (p_disjoint) else $error("sensor gpio driven");
	// image only moves on a host write or a reset, so a glitch cannot reach the store
	property p_backup_hold; !$past(i_write) |-> $stable(o_backup_image); endproperty
	a_backup_hold: assert property (p_backup_hold) else $error("backup moved");
	property p_store_pulse; o_store_strobe |=> !o_store_strobe; endproperty
	a_store_pulse: assert property (p_store_pulse) else $error("store too long");
	property p_store_cause; o_store_strobe |-> o_safe_state || $past(i_power_fail); endproperty
	a_store_cause: assert property (p_store_cause) else $error("store without cause");
endmodule
bind pimage_ctrl pimage_ctrl_checker #(.WD_BASE_CYCLES(WD_BASE_CYCLES)) pimage_ctrl_checker_i (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_write(i_write), .i_read(i_read),
	.i_power_fail(i_power_fail), .o_rdata(o_rdata), .o_gpio_output(o_gpio_output),
	.o_gpio_sensor(o_gpio_sensor), .o_outputs_off(o_outputs_off), .o_pwm_hiz(o_pwm_hiz),
	.o_safe_state(o_safe_state), .o_store_strobe(o_store_strobe),
	.o_backup_image(o_backup_image));

// file: sim/nv_store.sv
// nonvolatile backup store beside the controller
`timescale 1ns/1ns
module nv_store (
	input wire logic i_clock,
	input wire logic i_store_strobe,
	input wire logic [255:0] i_backup_image,
	output logic o_restore_valid,
	output logic [255:0] o_restore_image
);
	// ======================================================
	// storage, no reset so it survives power cycles
	logic [255:0] mem_reg = 256'h0;
	logic [7:0] tick_reg = 8'h00;
	logic valid_reg = 1'h0;
	always_ff @(posedge i_clock) begin
		tick_reg <= tick_reg + 8'h01;
		if (i_store_strobe)
			mem_reg <= i_backup_image;
	end
	always_ff @(posedge i_clock) begin
		if (i_store_strobe)
			valid_reg <= 1'h1;
	end
	assign o_restore_valid = valid_reg;
	// empty store shows a moving pattern
	assign o_restore_image = valid_reg ? mem_reg : {32{tick_reg}};
endmodule

// file: sim/test_pimage_ctrl.sv
// self-checking bench for the process-image controller
`timescale 1ns/1ns
`include "pimage_cfg.svh"
module test_pimage_ctrl;
	// ======================================================
	// stimulus and bookkeeping
	localparam logic [7:0] MODEL = 8'h3c; // arbitrary model code
	logic i_clock = 1'h0;
	logic i_nrst, i_write = 1'h0, i_read = 1'h0, i_cycle_done = 1'h0, i_cycle_crc_ok = 1'h1;
	logic feed = 1'h0, i_sensor_update = 1'h0, tn = 1'h0, ng = 1'h0, i_power_fail = 1'h0;
	logic o_store_strobe, o_safe_state, o_outputs_off, o_pwm_hiz, restore_valid;
	logic [1:0] gi = 2'h0;
	logic [3:0] o_gpio_output, o_gpio_sensor;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, ba, cb;
	logic [14:0] tv = 15'h0, hv = 15'h0;
	logic [15:0] tw, hw;
	logic [31:0] stores = 32'h0, tick = 32'h0;
	logic [255:0] restore_image, o_backup_image, img;
	int error_cnt = 0;
	int check_count = 0;
	pimage_ctrl #(.WD_BASE_CYCLES(10), .OWN_MODEL(MODEL)) pimage_ctrl_i (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_write(i_write), .i_read(i_read), .i_cycle_done(i_cycle_done),
		.i_cycle_crc_ok(i_cycle_crc_ok), .i_sensor_update(i_sensor_update),
		.i_sensor_index(gi), .i_sensor_tenths(tn), .i_sensor_negative(ng),
		.i_sensor_temp(tv), .i_sensor_humid(hv), .i_restore_valid(restore_valid),
		.i_restore_image(restore_image), .i_power_fail(i_power_fail), .o_rdata(o_rdata),
		.o_gpio_output(o_gpio_output), .o_gpio_sensor(o_gpio_sensor),
		.o_outputs_off(o_outputs_off), .o_pwm_hiz(o_pwm_hiz), .o_safe_state(o_safe_state),
		.o_store_strobe(o_store_strobe), .o_backup_image(o_backup_image));
	nv_store nv_store_i (.i_clock(i_clock), .i_store_strobe(o_store_strobe),
		.i_backup_image(o_backup_image), .o_restore_valid(restore_valid),
		.o_restore_image(restore_image));
	always #5 i_clock = ~i_clock;
	// transfer cycles every fourth clock while feeding
	always @(posedge i_clock) begin
		tick <= tick + 32'h1;
		i_cycle_done <= feed && tick[1:0] == 2'h0;
		if (o_store_strobe === 1'h1)
			stores <= stores + 32'h1;
	end
	task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'h1;
		@(posedge i_clock);
		i_write <= 1'h0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		i_addr <= a;
		i_read <= 1'h1;
		@(posedge i_clock);
		i_read <= 1'h0;
		// read data stand only in the cycle after the strobe edge
		#1;
		chk({248'h0, o_rdata & m}, {248'h0, e & m});
		@(posedge i_clock);
		@(posedge i_clock);
	endtask
	task automatic rst();
		i_nrst <= 1'h0;
		repeat (12) @(posedge i_clock);
		i_nrst <= 1'h1;
		@(posedge i_clock);
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [15:0] word(input logic t, input logic n, input logic [14:0] v);
		return t ? {n, v} : {v[7:0], 8'h00};
	endfunction
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h8ea18ca2));
		rst();
		rd(`OFS_SETTINGS_FIRST, 8'h00);
		rd(`OFS_SETTINGS_SECOND, 8'h00);
		rd(8'hf0, 8'h00);
		wr(`OFS_TRANSFER_MODE, 8'($urandom));
		rd(`OFS_TRANSFER_MODE, 8'h00);
		wr(`OFS_EXPECTED_MODEL, ~MODEL);
		rd(`OFS_STATE_REPORT, 8'h04, 8'h04);
		wr(`OFS_EXPECTED_MODEL, MODEL);
		rd(`OFS_STATE_REPORT, 8'h00, 8'h04);
		rd(`OFS_MODEL_REPORT, MODEL);
		wr(`OFS_GPIO_FUNCTION, 8'h5f);
		chk({o_gpio_sensor, o_gpio_output}, 8'h5a);
		rd(`OFS_CLIMATE_BASE + 8'h04, 8'h00);
		for (int k = 0; k < 12; k++) begin
			gi <= k[1] ? 2'h2 : 2'h0;
			tn <= k[0];
			ng <= 1'($urandom);
			tv <= k[0] ? 15'($urandom) : 15'($urandom & 255);
			hv <= k[0] ? 15'($urandom) : 15'($urandom & 255);
			i_sensor_update <= 1'h1;
			@(posedge i_clock);
			i_sensor_update <= 1'h0;
			@(posedge i_clock);
			tw = word(tn, ng, tv);
			hw = word(tn, 1'h0, hv);
			cb = `OFS_CLIMATE_BASE + {4'h0, gi, 2'h0};
			rd(cb, tw[7:0]);
			rd(cb + 8'h01, tw[15:8]);
			rd(cb + 8'h02, hw[7:0]);
			rd(cb + 8'h03, hw[15:8]);
		end
		wr(`OFS_SETTINGS_SECOND, 8'h04);
		for (int k = 0; k < 32; k++) begin
			ba = 8'($urandom);
			img[8*k+:8] = ba;
			wr(`OFS_BACKUP_BASE + 8'(k), ba);
		end
		chk(o_backup_image, img);
		for (int r = 0; r < 2; r++) begin
			i_power_fail <= 1'h1;
			repeat (4) @(posedge i_clock);
			i_power_fail <= 1'h0;
			rst();
			chk({224'h0, stores}, 256'h1);
			for (int k = 0; k < 32; k++)
				rd(`OFS_RESTORE_BASE + 8'(k), img[8*k+:8]);
		end
		wr(`OFS_GPIO_FUNCTION, 8'h0f);
		feed <= 1'h1;
		for (int c = 1; c < 16; c++) begin
			wr(`OFS_SETTINGS_FIRST, 8'(c));
			rd(`OFS_STATE_REPORT, {6'h0, c < 11, 1'h0}, 8'h02);
		end
		rd(`OFS_WARNING_REPORT, 8'h01, 8'h01);
		wr(`OFS_SETTINGS_FIRST, 8'h01);
		repeat (40) @(posedge i_clock);
		chk(o_safe_state, 1'h0);
		i_cycle_crc_ok <= 1'h0;
		repeat (6) @(posedge i_clock);
		chk(o_safe_state, 1'h0);
		repeat (20) @(posedge i_clock);
		chk({o_safe_state, o_outputs_off, o_pwm_hiz, o_gpio_output}, 7'h70);
		end_of_test();
	end
endmodule
